// ---- rtl/pwm_period_duty_generator.v ----
// Operation
// - resolution log2 of 4*(period+1), 10 max
// - 1024 duty steps at 10 bits, 256 at 8
// - duty beyond period leaves pin unchanged
// - timer prescale of 1, 4 or 16
// - sleep stops timer and freezes module state (here bus writes and status-clearing reads still take effect in sleep)
// - sleep keeps pin at its present level
// - after wake timer resumes from held value
// - time base derived from the system clock
// - reset makes pins inputs, registers default
// - rollover clears timer, sets pin, latches duty (here the pin is not set when the latched duty is zero)
// - duty is upper byte plus two control bits
// - pin clears when 10-bit base equals shadow
// - period is (limit+1)*4*prescale system clocks
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "pwm_period_duty_map.vh"

module pwm_period_duty_generator #(
   parameter N_CH = 2
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        sleep,
   output wire        pwm1_out,
   output wire        pwm1_oe_n,
   output wire        pwm2a_out,
   output wire        pwm2a_oe_n,
   output wire        pwm2b_out,
   output wire        pwm2b_oe_n,
   output wire        irq
);

   reg                 wr_pend_r;
   reg  [7:0]          wr_addr_r;
   reg                 alt_r;
   reg  [7:0]          period_limit_r;
   reg  [6:0]          tmr_ctl_r;
   reg  [7:0]          tmr_count_r;
   reg  [5:0]          pcnt_r;
   reg  [3:0]          post_r;
   reg  [2:0]          pin_dir_r;
   reg                 irq_status_r;
   reg                 irq_status_nxt;
   reg                 irq_mask_r;
   reg  [5:0]          ps_last;
   reg  [1:0]          base_lo;
   reg                 step_end;
   reg  [7:0]          rmux;
   wire                acc;
   wire                rd_acc;
   wire                run;
   wire                tick;
   wire                roll;
   wire                match_evt;
   wire [7:0]          wd;
   wire [9:0]          time_base;
   wire [9:0]          time_next;
   wire [6*N_CH-1:0]   ch_ctl;
   wire [8*N_CH-1:0]   ch_duty;
   wire [10*N_CH-1:0]  ch_shadow;
   wire [N_CH-1:0]     ch_lvl;
   wire [N_CH-1:0]     ch_pwm;

   // Zero-wait slave: every transfer completes with OKAY in one data phase.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign acc       = hsel & hready & htrans[1];
   assign rd_acc    = acc & ~hwrite;
   assign wd        = hwdata[7:0];

   // A write is held until its data phase ends, the first edge at which hwdata is valid.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (acc) begin
         wr_pend_r <= hwrite;
         wr_addr_r <= haddr[7:0];
      end else if (hready) begin
         wr_pend_r <= 1'b0;
      end
   end

   // The timer steps only while running and awake, so sleep freezes it in place.
   // Bus writes are still taken in sleep; only the time base and the pins stand still.
   assign run  = tmr_ctl_r[`TCON_RUN] & ~sleep;
   assign tick = run & (pcnt_r == ps_last);
   assign roll = tick & (tmr_count_r == period_limit_r);
   assign match_evt = roll & (post_r == tmr_ctl_r[`TCON_POST_HI:`TCON_POST_LO]);

   always @* begin
      case (tmr_ctl_r[1:0])
         `PS_DIV1: begin
            ps_last  = `PS_LAST_DIV1;
            base_lo  = pcnt_r[1:0];
            step_end = 1'b1;
         end
         `PS_DIV4: begin
            ps_last  = `PS_LAST_DIV4;
            base_lo  = pcnt_r[3:2];
            step_end = (pcnt_r[1:0] == 2'h3);
         end
         default: begin
            ps_last  = `PS_LAST_DIV16;
            base_lo  = pcnt_r[5:4];
            step_end = (pcnt_r[3:0] == 4'hF);
         end
      endcase
   end

   // The low two bits come from the clock phase or the prescaler, whichever is active.
   assign time_base = {tmr_count_r, base_lo};

   // The pin must fall on the edge at which the time base reaches the shadow, not a
   // clock later, so the compare looks at the value that this edge will show.
   assign time_next = time_base + 10'h001;

   // Prescaler runs straight off hclk; no other clock feeds the time base.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pcnt_r <= 6'h00;
      end else if (wr_pend_r && (wr_addr_r == `OFF_TMR_COUNT ||
                                 wr_addr_r == `OFF_TMR_CTL)) begin
         pcnt_r <= 6'h00;
      end else if (run) begin
         pcnt_r <= tick ? 6'h00 : pcnt_r + 6'h01;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr_count_r <= `RST_TMR_COUNT;
      end else if (wr_pend_r && wr_addr_r == `OFF_TMR_COUNT) begin
         tmr_count_r <= wd;
      end else if (roll) begin
         tmr_count_r <= 8'h00;
      end else if (tick) begin
         tmr_count_r <= tmr_count_r + 8'h01;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         post_r <= 4'h0;
      end else if (wr_pend_r && wr_addr_r == `OFF_TMR_CTL) begin
         post_r <= 4'h0;
      end else if (roll) begin
         post_r <= match_evt ? 4'h0 : post_r + 4'h1;
      end
   end

   // Global registers; all return to their defaults on reset.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alt_r          <= `RST_ALT_PIN;
         period_limit_r <= `RST_PERIOD;
         tmr_ctl_r      <= `RST_TMR_CTL;
         pin_dir_r      <= `RST_PIN_DIR;
         irq_mask_r     <= `RST_IRQ;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            `OFF_ALT_PIN:  alt_r          <= wd[`ALT_CH2_SEL];
            `OFF_PERIOD:   period_limit_r <= wd;
            `OFF_TMR_CTL:  tmr_ctl_r      <= wd[6:0];
            `OFF_PIN_DIR:  pin_dir_r      <= wd[2:0];
            `OFF_IRQ_MASK: irq_mask_r     <= wd[0];
            default:       alt_r          <= alt_r;
         endcase
      end
   end

   // A match in the same cycle as the clearing read still leaves the flag set.
   always @* begin
      irq_status_nxt = irq_status_r;
      if (rd_acc && haddr[7:0] == `OFF_IRQ_STATUS) begin
         irq_status_nxt = 1'b0;
      end
      if (match_evt) begin
         irq_status_nxt = 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_r <= `RST_IRQ;
      end else begin
         irq_status_r <= irq_status_nxt;
      end
   end

   assign irq = irq_status_r & irq_mask_r;

   genvar i;
   generate
      for (i = 0; i < N_CH; i = i + 1) begin : g_ch
         localparam [7:0] OFF_CTL = (i == 0) ? `OFF_CH1_CTL    : `OFF_CH2_CTL;
         localparam [7:0] OFF_DTY = (i == 0) ? `OFF_CH1_DUTY   : `OFF_CH2_DUTY;
         localparam [7:0] OFF_SHD = (i == 0) ? `OFF_CH1_SHADOW : `OFF_CH2_SHADOW;
         reg  [5:0] ctl_r;
         reg  [7:0] duty_r;
         reg  [9:0] shadow_r;
         reg        lvl_r;
         wire [9:0] duty_full;
         wire       pwm_on;
         wire       clr_hit;

         // Ten bits of duty give 1024 settings; with a short period fewer are reachable.
         assign duty_full = {duty_r, ctl_r[`CTL_DLOW_HI:`CTL_DLOW_LO]};
         assign pwm_on    = ctl_r[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_PWM;
         // Comparing with the next time base makes the high time exactly the duty
         // count times the prescale, with no extra clock at the end.
         assign clr_hit   = run & step_end & (time_next == shadow_r);

         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ctl_r  <= `RST_CTL;
               duty_r <= `RST_DUTY;
            end else if (wr_pend_r && wr_addr_r == OFF_CTL) begin
               ctl_r  <= wd[5:0];
            end else if (wr_pend_r && wr_addr_r == OFF_DTY) begin
               duty_r <= wd;
            end
         end

         // Shadow is software-writable only outside PWM mode.
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               shadow_r <= `RST_SHADOW;
               lvl_r    <= 1'b0;
            end else if (!pwm_on) begin
               lvl_r <= 1'b0;
               if (wr_pend_r && wr_addr_r == OFF_SHD) begin
                  shadow_r <= {wd, shadow_r[1:0]};
               end
            end else if (roll) begin
               shadow_r <= duty_full;
               lvl_r    <= (duty_full != 10'h000);
            end else if (clr_hit) begin
               // A duty beyond the period never matches, so the pin keeps its level.
               lvl_r <= 1'b0;
            end
         end

         assign ch_ctl[6*i +: 6]     = ctl_r;
         assign ch_duty[8*i +: 8]    = duty_r;
         assign ch_shadow[10*i +: 10] = shadow_r;
         assign ch_lvl[i]            = lvl_r;
         assign ch_pwm[i]            = pwm_on;
      end
   endgenerate

   // A pin drives only while its direction bit is clear and its channel is in PWM mode.
   // The level keeps running behind a disabled driver, so enabling it mid-pulse cuts a pulse.
   assign pwm1_out   = ch_lvl[0];
   assign pwm1_oe_n  = pin_dir_r[0] | ~ch_pwm[0];
   assign pwm2a_out  = ch_lvl[1] & ~alt_r;
   assign pwm2a_oe_n = pin_dir_r[1] | ~ch_pwm[1] | alt_r;
   assign pwm2b_out  = ch_lvl[1] & alt_r;
   assign pwm2b_oe_n = pin_dir_r[2] | ~ch_pwm[1] | ~alt_r;

   always @* begin
      case (haddr[7:0])
         `OFF_ALT_PIN:    rmux = {7'h00, alt_r};
         `OFF_CH1_CTL:    rmux = {2'h0, ch_ctl[5:0]};
         `OFF_CH2_CTL:    rmux = {2'h0, ch_ctl[11:6]};
         `OFF_CH1_DUTY:   rmux = ch_duty[7:0];
         `OFF_CH1_SHADOW: rmux = ch_shadow[9:2];
         `OFF_CH2_DUTY:   rmux = ch_duty[15:8];
         `OFF_CH2_SHADOW: rmux = ch_shadow[19:12];
         `OFF_PERIOD:     rmux = period_limit_r;
         `OFF_TMR_CTL:    rmux = {1'h0, tmr_ctl_r};
         `OFF_TMR_COUNT:  rmux = tmr_count_r;
         `OFF_PIN_DIR:    rmux = {5'h00, pin_dir_r};
         `OFF_IRQ_STATUS: rmux = {7'h00, irq_status_r};
         `OFF_IRQ_MASK:   rmux = {7'h00, irq_mask_r};
         default:         rmux = 8'h00;
      endcase
   end

   // Read data is captured in the address phase, so a read straight after a
   // write to the same register returns the value before that write.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_acc) begin
         hrdata <= {24'h000000, rmux};
      end
   end

endmodule // pwm_period_duty_generator

// ---- inc/pwm_period_duty_map.vh ----
`ifndef PWM_PERIOD_DUTY_MAP_VH
`define PWM_PERIOD_DUTY_MAP_VH

// Byte offsets on the register bus, one 32-bit word per register.
`define OFF_ALT_PIN     8'h00
`define OFF_CH1_CTL     8'h04
`define OFF_CH2_CTL     8'h08
`define OFF_CH1_DUTY    8'h0C
`define OFF_CH1_SHADOW  8'h10
`define OFF_CH2_DUTY    8'h14
`define OFF_CH2_SHADOW  8'h18
`define OFF_PERIOD      8'h1C
`define OFF_TMR_CTL     8'h20
`define OFF_TMR_COUNT   8'h24
`define OFF_PIN_DIR     8'h28
`define OFF_IRQ_STATUS  8'h2C
`define OFF_IRQ_MASK    8'h30

// Field positions.
`define CTL_MODE_HI     3
`define CTL_MODE_LO     2
`define CTL_DLOW_HI     5
`define CTL_DLOW_LO     4
`define TCON_RUN        2
`define TCON_POST_HI    6
`define TCON_POST_LO    3
`define ALT_CH2_SEL     0

// Mode and prescale encodings.
`define MODE_PWM        2'h3
`define PS_DIV1         2'h0
`define PS_DIV4         2'h1

// Prescaler terminal counts: four system clocks per timer step times the prescale.
`define PS_LAST_DIV1    6'h03
`define PS_LAST_DIV4    6'h0F
`define PS_LAST_DIV16   6'h3F

// Reset values.
`define RST_ALT_PIN     1'h0
`define RST_CTL         6'h00
`define RST_DUTY        8'h00
`define RST_SHADOW      10'h000
`define RST_PERIOD      8'hFF
`define RST_TMR_CTL     7'h00
`define RST_TMR_COUNT   8'h00
`define RST_PIN_DIR     3'h7
`define RST_IRQ         1'h0

`endif

// ---- testbench/pwm_period_duty_generator_chk.sv ----
`timescale 1ns/1ps
module pwm_period_duty_generator_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        sleep,
   input wire logic        pwm1_out,
   input wire logic        pwm1_oe_n,
   input wire logic        irq
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic addr_ph;
   logic bus_wr;
   logic bus_rd;
   logic stat_rd;
   logic mask_wr;
   assign addr_ph = hsel && hreadyout && htrans[1];
   assign bus_wr = addr_ph && hwrite;
   assign bus_rd = addr_ph && !hwrite;
   assign stat_rd = bus_rd && haddr[7:0] == 8'h2C;
   assign mask_wr = bus_wr && haddr[7:0] == 8'h30;
   sequence quiet_sleep;
      (sleep && !addr_ph)[*2];
   endsequence
   sequence new_pulse;
      $rose(pwm1_out);
   endsequence
   a_ready_high: assert property (hreadyout)
      else $error("wait state seen");
   a_resp_okay: assert property (!hresp)
      else $error("error response seen");
   a_sleep_pin: assert property (sleep |=> $stable(pwm1_out))
      else $error("pin moved in sleep");
   a_sleep_irq: assert property (quiet_sleep |=> $stable(irq))
      else $error("state moved in sleep");
   a_period_min: assert property (new_pulse |=> (!$rose(pwm1_out))[*3])
      else $error("period below four clocks");
   a_irq_fall: assert property ($fell(irq) |-> $past(stat_rd) || $past(mask_wr, 2))
      else $error("irq fell without cause");
   a_rdata_hold: assert property (!$past(bus_rd) |-> $stable(hrdata))
      else $error("read data moved");
   a_oe_by_write: assert property ($changed(pwm1_oe_n) |-> $past(bus_wr, 2))
      else $error("driver enable moved alone");
endmodule // pwm_period_duty_generator_chk

// ---- testbench/pwm_pin_load.sv ----
`timescale 1ns/1ps
module pwm_pin_load (
   input  wire logic hclk,
   input  wire logic drive,
   input  wire logic oe_n,
   output int        period_len,
   output int        high_len
);
   logic pin;
   logic pin_r = 1'b0;
   int   per_r = 0;
   int   hi_r = 0;
   // With the driver off, the load resistor pulls the line low.
   assign pin = oe_n ? 1'b0 : drive;
   always @(posedge hclk) begin
      pin_r <= pin;
      per_r <= (pin && !pin_r) ? 1 : per_r + 1;
      hi_r <= pin ? hi_r + 1 : 0;
      if (pin && !pin_r)
         period_len <= per_r;
      if (!pin && pin_r)
         high_len <= hi_r;
   end
endmodule // pwm_pin_load

// ---- testbench/pwm_period_duty_generator_tb.sv ----
`timescale 1ns/1ps
module pwm_period_duty_generator_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        sleep = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, pwm1_out, pwm1_oe_n, irq;
   logic        pwm2a_out, pwm2a_oe_n, pwm2b_out, pwm2b_oe_n;
   wire         hready = hreadyout;
   int          fail_count = 0;
   int          compares = 0;
   int          period_len;
   int          high_len;
   logic [15:0] rst_t [9] = '{16'h0000, 16'h0400, 16'h0800, 16'h1CFF, 16'h2000, 16'h2400,
                             16'h2807, 16'h2C00, 16'h3000};
   always #4 hclk = ~hclk;
   pwm_period_duty_generator u_dut (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (hsize),
      .hwdata     (hwdata),
      .hready     (hready),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .sleep      (sleep),
      .pwm1_out   (pwm1_out),
      .pwm1_oe_n  (pwm1_oe_n),
      .pwm2a_out  (pwm2a_out),
      .pwm2a_oe_n (pwm2a_oe_n),
      .pwm2b_out  (pwm2b_out),
      .pwm2b_oe_n (pwm2b_oe_n),
      .irq        (irq)
   );
   pwm_pin_load u_load (.hclk, .drive(pwm1_out), .oe_n(pwm1_oe_n), .period_len, .high_len);
   task automatic final_report;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic hs;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (n == 64) begin
         fail_count++;
         final_report;
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hs;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hs;
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      ahb(1'b0, a, 32'h0, q);
   endtask
   task automatic t_reset;
      logic [31:0] d;
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      check("oe_n", {pwm1_oe_n, pwm2a_oe_n, pwm2b_oe_n}, 3'h7);
      check("out", {pwm1_out, pwm2a_out, pwm2b_out, irq}, 4'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rst_t[i]) begin
         rd(rst_t[i][15:8], d);
         check("reset value", d, {24'h0, rst_t[i][7:0]});
      end
      $display("reset test done");
   endtask
   task automatic t_pwm(input logic [1:0] ps, input int m);
      logic [31:0] d;
      int n;
      wr(8'h28, 32'h07);
      wr(8'h1C, 32'h03);
      wr(8'h04, 32'h1C);
      wr(8'h0C, 32'h01);
      rd(8'h2C, d);
      wr(8'h30, 32'h01);
      wr(8'h20, {29'h0, 1'b1, ps});
      n = 0;
      while (irq !== 1'b1 && n < 4000) begin
         @(posedge hclk);
         n++;
      end
      check("irq", irq, 1'b1);
      if (n == 4000)
         final_report;
      wr(8'h28, 32'h06);
      repeat (48 * m) @(posedge hclk);
      check("period", period_len, 16 * m);
      check("high", high_len, 5 * m);
      wr(8'h30, 32'h00);
      @(posedge hclk);
      check("masked irq", irq, 1'b0);
      wr(8'h20, 32'h00);
      rd(8'h2C, d);
      check("status", d, 32'h1);
      rd(8'h2C, d);
      check("cleared", d, 32'h0);
      $display("pwm test done");
   endtask
   task automatic t_edges;
      int n;
      wr(8'h00, 32'h01);
      wr(8'h08, 32'h0C);
      wr(8'h14, 32'h01);
      wr(8'h28, 32'h00);
      @(posedge hclk);
      check("pin sel", {pwm2a_oe_n, pwm2b_oe_n}, 2'h2);
      wr(8'h0C, 32'h00);
      wr(8'h04, 32'h0C);
      wr(8'h20, 32'h04);
      repeat (40) @(posedge hclk);
      check("zero duty", pwm1_out, 1'b0);
      n = 0;
      while (pwm2b_out !== 1'b1 && n < 32) begin
         @(posedge hclk);
         n++;
      end
      check("pin b level", {pwm2a_out, pwm2b_out}, 2'h1);
      if (n == 32)
         final_report;
      wr(8'h0C, 32'h10);
      repeat (40) @(posedge hclk);
      check("long duty", pwm1_out, 1'b1);
      repeat (7) @(posedge hclk);
      check("long duty", pwm1_out, 1'b1);
      $display("edge test done");
   endtask
   task automatic t_sleep;
      logic [31:0] v;
      logic [31:0] q;
      wr(8'h1C, 32'hFF);
      repeat (20) @(posedge hclk);
      sleep <= 1'b1;
      rd(8'h24, v);
      repeat (100) @(posedge hclk);
      rd(8'h24, q);
      check("frozen count", q, v);
      sleep <= 1'b0;
      rd(8'h24, q);
      check("resumed count", q, v);
      repeat (200) @(posedge hclk);
      rd(8'h24, q);
      check("count moves", q != v, 1'b1);
      $display("sleep test done");
   endtask
   initial begin
      t_reset;
      t_pwm(2'h0, 1);
      t_pwm(2'h1, 4);
      t_pwm(2'h2, 16);
      t_edges;
      t_sleep;
      t_reset;
      final_report;
   end
endmodule // pwm_period_duty_generator_tb
bind pwm_period_duty_generator pwm_period_duty_generator_chk u_chk (
   .hclk      (hclk),
   .hresetn   (hresetn),
   .hsel      (hsel),
   .haddr     (haddr),
   .htrans    (htrans),
   .hwrite    (hwrite),
   .hrdata    (hrdata),
   .hreadyout (hreadyout),
   .hresp     (hresp),
   .sleep     (sleep),
   .pwm1_out  (pwm1_out),
   .pwm1_oe_n (pwm1_oe_n),
   .irq       (irq)
);
